// ==== shared/sdram_cmd_pkg.sv ====
/*
 package of the two-bank synchronous dram command block: command codes, bank states,
 timing counts and widths.
 assumes a single 125 MHz clock shared by controller and device ends.
*/
package sdram_cmd_pkg;
   // ---------------------------------------------------------------
   // widths and clock
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int BANK_BIT = 9;            // bank_select_bit position in the address
   localparam int CLK_PERIOD_NS = 8;
   // ---------------------------------------------------------------
   // timing in ns and in cycles (least times round up)
   // ---------------------------------------------------------------
   localparam int ROW_TO_COLUMN_DELAY_NS = 24;
   localparam int PRECHARGE_TIME_NS = 24;
   localparam int WRITE_RECOVERY_NS = 8;
   localparam int DATA_IN_TO_ACTIVE_DELAY_NS = 32;
   localparam int REFRESH_CYCLE_NS = 80;
   localparam int MODE_SET_TO_COMMAND_DELAY_NS = 16;
   localparam int RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DAL_CYC = (DATA_IN_TO_ACTIVE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_CYC = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MCD_CYC = (MODE_SET_TO_COMMAND_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BURST_LEN = 4;
   localparam int CNT_W = 8;
   // ---------------------------------------------------------------
   // commands: {cs_n, ras_n, cas_n, we_n}
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      deselect_cmd      = 4'h8,
      no_operation_cmd  = 4'h7,
      burst_stop_cmd    = 4'h6,
      read_cmd          = 4'h5,
      write_cmd         = 4'h4,
      activate_cmd      = 4'h3,
      precharge_cmd     = 4'h2,
      refresh_cmd       = 4'h1,
      mode_set_cmd      = 4'h0
   } cmd_e;
   // ---------------------------------------------------------------
   // bank states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE       = 4'h0,
      ST_ACT_WAIT   = 4'h1,
      ST_ROW_ACTIVE = 4'h3,
      ST_WRITE      = 4'h2,
      ST_WR_REC     = 4'h6,
      ST_WRITE_AP   = 4'h7,
      ST_WR_REC_AP  = 4'h5,
      ST_PRECHARGE  = 4'h4,
      ST_REFRESH    = 4'hc,
      ST_MODE_SET   = 4'hd
   } bank_state_e;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam int AP_BIT = 8;              // auto-precharge flag position on column commands
endpackage : sdram_cmd_pkg

// ==== shared/sdram_cmd_if.sv ====
/*
 interface joining the command controller and the dram command end.
 assumes both ends share clk_i and rst_i supplied by the testbench.
*/
`timescale 1ns/1ps
interface sdram_cmd_if;
   import sdram_cmd_pkg::*;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [ADDR_W-1:0] addr;
   // ---------------------------------------------------------------
   // modports
   // ---------------------------------------------------------------
   modport ctrl (output cs_n, output ras_n, output cas_n, output we_n, output addr);
   modport dev (input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface : sdram_cmd_if

// ==== design/sdram_bank_dev.sv ====
/*
 device end: per-bank command legality state machines of a two-bank sdram, mode register
 and illegal-command flag.
 assumes commands synchronous to clk_i, driven by the controller end through sdram_cmd_if.
*/
`timescale 1ns/1ps
module sdram_bank_dev
   import sdram_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // command pins
   sdram_cmd_if.dev cmd,
   // status
   output logic [1:0] bank_idle_o,
   output logic [1:0] bank_active_o,
   output logic [ADDR_W-1:0] mode_reg_o,
   output logic illegal_o,
   output logic [3:0] read_start_o
);
   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic [3:0] pins;
   cmd_e cmd_now;
   logic sel_bank;
   logic is_nopc;
   assign pins = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
   assign cmd_now = cmd.cs_n ? deselect_cmd : cmd_e'(pins);
   assign sel_bank = cmd.addr[BANK_BIT];
   assign is_nopc = (cmd_now == deselect_cmd) || (cmd_now == no_operation_cmd) ||
                    (cmd_now == burst_stop_cmd);

   bank_state_e st_reg [2];
   logic [CNT_W-1:0] cnt_reg [2];
   logic [1:0] bank_ill;
   logic [1:0] rd_hit;

   // ---------------------------------------------------------------
   // one state machine per bank
   // ---------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : g_bank
         bank_state_e st_next;
         logic [CNT_W-1:0] cnt_next;
         logic ill_next;
         logic mine;
         logic other_busy;
         logic col_ap;
         assign mine = (sel_bank == b[0]);
         assign col_ap = cmd.addr[AP_BIT];
         assign other_busy = (st_reg[1-b] != ST_IDLE);
         // next state and legality of this bank
         always_comb
         begin
            st_next = st_reg[b];
            cnt_next = (cnt_reg[b] != CNT_ZERO) ? cnt_reg[b] - CNT_ONE : CNT_ZERO;
            ill_next = 1'b0;
            unique case (st_reg[b])
               ST_IDLE:
               begin
                  if (cmd_now == refresh_cmd || cmd_now == mode_set_cmd)
                  begin
                     // both banks must be idle; this bank stays idle when the other is busy
                     if (other_busy)
                        ill_next = 1'b1;
                     else
                     begin
                        st_next = (cmd_now == refresh_cmd) ? ST_REFRESH : ST_MODE_SET;
                        cnt_next = (cmd_now == refresh_cmd) ? CNT_W'(RC_CYC - 1) : CNT_W'(MCD_CYC - 1);
                     end
                  end
                  else if (mine && cmd_now == activate_cmd)
                  begin
                     st_next = ST_ACT_WAIT;
                     cnt_next = CNT_W'(RCD_CYC - 1);
                  end
                  else if (mine && (cmd_now == read_cmd || cmd_now == write_cmd))
                     ill_next = 1'b1;
               end
               ST_ACT_WAIT:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                     st_next = ST_ROW_ACTIVE;
                  if (!is_nopc && (mine || cmd_now == refresh_cmd || cmd_now == mode_set_cmd))
                     ill_next = 1'b1;
               end
               ST_ROW_ACTIVE, ST_WR_REC:
               begin
                  if (st_reg[b] == ST_WR_REC && cnt_reg[b] == CNT_ZERO)
                     st_next = ST_ROW_ACTIVE;
                  if (mine && cmd_now == write_cmd)
                  begin
                     st_next = col_ap ? ST_WRITE_AP : ST_WRITE;
                     cnt_next = CNT_W'(BURST_LEN - 1);
                  end
                  else if (mine && cmd_now == read_cmd)
                     st_next = col_ap ? ST_PRECHARGE : ST_ROW_ACTIVE;
                  else if (mine && cmd_now == precharge_cmd && st_reg[b] == ST_ROW_ACTIVE ||
                           cmd_now == precharge_cmd && cmd.addr[AP_BIT] && st_reg[b] == ST_ROW_ACTIVE)
                  begin
                     st_next = ST_PRECHARGE;
                     cnt_next = CNT_W'(RP_CYC - 1);
                  end
                  else if (!is_nopc && (mine || cmd_now == refresh_cmd || cmd_now == mode_set_cmd))
                     ill_next = 1'b1;
                  if (mine && cmd_now == read_cmd && col_ap)
                     cnt_next = CNT_W'(RP_CYC - 1);
               end
               ST_WRITE:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                  begin
                     st_next = ST_WR_REC;
                     cnt_next = CNT_W'(WR_CYC - 1);
                  end
                  if (mine && cmd_now == burst_stop_cmd)
                     st_next = ST_ROW_ACTIVE;
               end
               ST_WRITE_AP:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                  begin
                     st_next = ST_WR_REC_AP;
                     cnt_next = CNT_W'(DAL_CYC - 1);
                  end
                  if (!(cmd_now == deselect_cmd || cmd_now == no_operation_cmd) &&
                      (mine || cmd_now == refresh_cmd || cmd_now == mode_set_cmd || cmd_now == burst_stop_cmd))
                     ill_next = 1'b1;
               end
               ST_WR_REC_AP:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                     st_next = ST_IDLE;
                  if (!is_nopc && (mine || cmd_now == refresh_cmd || cmd_now == mode_set_cmd))
                     ill_next = 1'b1;
               end
               ST_PRECHARGE:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                     st_next = ST_IDLE;
                  if (!is_nopc && cmd_now != precharge_cmd &&
                      (mine || cmd_now == refresh_cmd || cmd_now == mode_set_cmd))
                     ill_next = 1'b1;
               end
               ST_REFRESH, ST_MODE_SET:
               begin
                  if (cnt_reg[b] == CNT_ZERO)
                     st_next = ST_IDLE;
                  if (!is_nopc && b == 0)
                     ill_next = 1'b1;
               end
               default:
                  st_next = ST_IDLE;
            endcase
         end
         assign bank_ill[b] = ill_next;
         assign rd_hit[b] = mine && cmd_now == read_cmd &&
                            (st_reg[b] == ST_ROW_ACTIVE || st_reg[b] == ST_WR_REC);
         // state registers sample pins on the rising edge
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               st_reg[b] <= ST_IDLE;
               cnt_reg[b] <= CNT_ZERO;
            end
            else
            begin
               st_reg[b] <= st_next;
               cnt_reg[b] <= cnt_next;
            end
         end
         // per-bank status outputs
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               bank_idle_o[b] <= 1'b1;
               bank_active_o[b] <= 1'b0;
               read_start_o[b] <= 1'b0;
               read_start_o[b+2] <= 1'b0;
            end
            else
            begin
               bank_idle_o[b] <= (st_next == ST_IDLE);
               bank_active_o[b] <= (st_next == ST_ROW_ACTIVE);
               read_start_o[b] <= rd_hit[b];
               read_start_o[b+2] <= rd_hit[b] && col_ap;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // mode register and illegal flag
   // ---------------------------------------------------------------
   logic mode_load;
   assign mode_load = cmd_now == mode_set_cmd && st_reg[0] == ST_IDLE && st_reg[1] == ST_IDLE;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_reg_o <= '0;
         illegal_o <= 1'b0;
      end
      else
      begin
         if (mode_load)
            mode_reg_o <= cmd.addr;
         illegal_o <= |bank_ill;
      end
   end
endmodule : sdram_bank_dev

// ==== design/sdram_cmd_ctrl.sv ====
/*
 controller end: issues one requested command at a time, holding off any command while the timer
 of its bank or the chip-wide timer still runs; nop otherwise.
 assumes a user that holds req_i until ack_o.
*/
`timescale 1ns/1ps
module sdram_cmd_ctrl
   import sdram_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // user request
   input wire logic req_i,
   input wire logic [3:0] req_cmd_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   output logic ack_o,
   // command pins
   sdram_cmd_if.ctrl cmd
);
   // ---------------------------------------------------------------
   // per-bank and global busy timers
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] bank_wait_reg [2];
   logic [CNT_W-1:0] all_wait_reg;
   logic [1:0] open_reg;
   logic bsel;
   logic go;
   logic [CNT_W-1:0] hold;
   assign bsel = req_addr_i[BANK_BIT];
   // the request may go when its bank and the chip are quiet
   assign go = req_i && !ack_o && all_wait_reg == CNT_ZERO &&
               (bank_wait_reg[bsel] == CNT_ZERO) &&
               ((req_cmd_i != refresh_cmd && req_cmd_i != mode_set_cmd) ||
                (open_reg == 2'b00 && bank_wait_reg[!bsel] == CNT_ZERO));
   // hold time the issued command imposes on its bank
   assign hold = (req_cmd_i == activate_cmd) ? CNT_W'(RCD_CYC) :
                 (req_cmd_i == precharge_cmd) ? CNT_W'(RP_CYC) :
                 (req_cmd_i == write_cmd && req_addr_i[AP_BIT]) ? CNT_W'(BURST_LEN + DAL_CYC + 1) :
                 (req_cmd_i == write_cmd) ? CNT_W'(BURST_LEN + WR_CYC) :
                 (req_cmd_i == read_cmd && req_addr_i[AP_BIT]) ? CNT_W'(BURST_LEN + RP_CYC) : CNT_ZERO;
   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : g_bank
         // bank timer and open-row tracking
         always_ff @(posedge clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               bank_wait_reg[b] <= CNT_ZERO;
               open_reg[b] <= 1'b0;
            end
            else if (go && bsel == b[0])
            begin
               bank_wait_reg[b] <= hold;
               open_reg[b] <= (req_cmd_i == activate_cmd) ||
                              (open_reg[b] && req_cmd_i != precharge_cmd && !req_addr_i[AP_BIT]);
            end
            else if (bank_wait_reg[b] != CNT_ZERO)
               bank_wait_reg[b] <= bank_wait_reg[b] - CNT_ONE;
         end
      end
   endgenerate
   // chip-wide timer after refresh and mode set
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         all_wait_reg <= CNT_ZERO;
      else if (go && req_cmd_i == refresh_cmd)
         all_wait_reg <= CNT_W'(RC_CYC);
      else if (go && req_cmd_i == mode_set_cmd)
         all_wait_reg <= CNT_W'(MCD_CYC);
      else if (all_wait_reg != CNT_ZERO)
         all_wait_reg <= all_wait_reg - CNT_ONE;
   end
   // pin drive: command for one cycle, else nop
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= 4'h8;
         cmd.addr <= '0;
         ack_o <= 1'b0;
      end
      else
      begin
         {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= go ? req_cmd_i : 4'h7;
         cmd.addr <= go ? req_addr_i : cmd.addr;
         ack_o <= go;
      end
   end
endmodule : sdram_cmd_ctrl

// ==== verification/sdram_cmd_props.sv ====
/*
 checker of the command pins between controller and device end, and of the device status.
 assumes it is instantiated in tb beside the interface, single clock, rst_i async high.
*/
`timescale 1ns/1ps
module sdram_cmd_props
   import sdram_cmd_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // command pins
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ADDR_W-1:0] addr,
   // controller user side
   input wire logic req_i,
   input wire logic ack_o,
   // device status
   input wire logic [1:0] bank_idle_o,
   input wire logic [1:0] bank_active_o,
   input wire logic [ADDR_W-1:0] mode_reg_o,
   input wire logic illegal_o,
   input wire logic [3:0] read_start_o
);
   // ---------------------------------------------------------------
   // pin decode
   // ---------------------------------------------------------------
   wire logic [3:0] pin_cmd = cs_n ? 4'h8 : {cs_n, ras_n, cas_n, we_n};
   wire logic quiet = (pin_cmd == no_operation_cmd) || (pin_cmd == deselect_cmd);
   wire logic act0 = (pin_cmd == activate_cmd) && !addr[BANK_BIT];
   wire logic col0 = ((pin_cmd == read_cmd) || (pin_cmd == write_cmd)) && !addr[BANK_BIT];
   wire logic pre0 = (pin_cmd == precharge_cmd) && !addr[BANK_BIT];
   wire logic rd_plain = (pin_cmd == read_cmd) && !addr[AP_BIT];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   chk_never_illegal: assert property (!illegal_o)
      else $error("controller issued a command the device flagged illegal");
   chk_cmd_then_nop: assert property (!quiet |=> pin_cmd == no_operation_cmd)
      else $error("command not followed by no operation");
   chk_ack_with_cmd: assert property (ack_o |-> !quiet ##1 !ack_o)
      else $error("ack without a command on the pins");
   chk_ack_after_req: assert property (ack_o |-> $past(req_i))
      else $error("ack without a pending request");
   chk_rcd_gap_kept: assert property (col0 |-> !$past(act0, 1) && !$past(act0, 2))
      else $error("column command too soon after activate");
   chk_act_leaves_idle: assert property (act0 |=> !bank_idle_o[0] ##[1:5] bank_active_o[0])
      else $error("activate did not lead to row active in time");
   chk_mode_load: assert property (pin_cmd == mode_set_cmd |=> mode_reg_o == $past(addr))
      else $error("mode register not loaded from address");
   chk_read_pulse: assert property (rd_plain |=> read_start_o == ($past(addr[BANK_BIT]) ? 4'h2 : 4'h1))
      else $error("read start pulse on wrong bank");
   chk_refresh_hold: assert property (pin_cmd == refresh_cmd |=> quiet [*8])
      else $error("command during refresh cycle");
   chk_mode_hold: assert property (pin_cmd == mode_set_cmd |=> quiet)
      else $error("command right after mode set");
   chk_pre_idle: assert property (pre0 |-> ##[2:6] bank_idle_o[0])
      else $error("bank not idle after precharge time");
   // main scenarios seen
   cov_activate: cover property (act0 ##1 quiet);
   cov_refresh: cover property (pin_cmd == refresh_cmd);
   cov_read: cover property (read_start_o != 4'h0);
endmodule : sdram_cmd_props

// ==== verification/tb.sv ====
/*
 testbench: controller and device end joined by one interface; a second device end driven
 directly by the bench, breaking command rules on purpose.
 assumes the package, interface and both design modules are compiled first.
*/
`timescale 1ns/1ps
module tb;
   import sdram_cmd_pkg::*;
   logic clk_i, rst_i, req_i, ack_o, illegal_o, illegal2;
   logic [3:0] req_cmd_i, read_start_o, rs2;
   logic [ADDR_W-1:0] req_addr_i, mode_reg_o, mode2;
   logic [1:0] bank_idle_o, bank_active_o, idle2, active2;
   logic [31:0] lfsr_reg;
   logic [4:0] q1[$];
   logic [4:0] q2[$];
   int err_total, comparisons;
   sdram_cmd_if link_if();
   sdram_cmd_if drv_if();
   // ---------------------------------------------------------------
   // instances
   // ---------------------------------------------------------------
   sdram_cmd_ctrl sdram_cmd_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_cmd_i(req_cmd_i),
      .req_addr_i(req_addr_i), .ack_o(ack_o), .cmd(link_if.ctrl));
   sdram_bank_dev sdram_bank_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd(link_if.dev), .bank_idle_o(bank_idle_o),
      .bank_active_o(bank_active_o), .mode_reg_o(mode_reg_o), .illegal_o(illegal_o), .read_start_o(read_start_o));
   if (1)
   begin : fault_side
      sdram_bank_dev sdram_bank_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd(drv_if.dev), .bank_idle_o(idle2),
         .bank_active_o(active2), .mode_reg_o(mode2), .illegal_o(illegal2), .read_start_o(rs2));
   end
   sdram_cmd_props sdram_cmd_props_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link_if.cs_n),
      .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n), .addr(link_if.addr), .req_i(req_i),
      .ack_o(ack_o), .bank_idle_o(bank_idle_o), .bank_active_o(bank_active_o), .mode_reg_o(mode_reg_o),
      .illegal_o(illegal_o), .read_start_o(read_start_o));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic rnd(output logic [7:0] r);
      lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      r = lfsr_reg[7:0];
   endtask : rnd
   task automatic take(ref logic [4:0] q[$], input logic [4:0] got);
      logic [4:0] e;
      e = (q.size() > 0) ? q.pop_front() : 5'h00;
      comparisons++;
      if (got !== e)
      begin
         err_total++;
         $display("Error %0t: result %h expected %h", $realtime, got, e);
      end
   endtask : take
   task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] e);
      comparisons++;
      if (got !== e)
      begin
         err_total++;
         $display("Error %0t: status %h expected %h", $realtime, got, e);
      end
   endtask : chk
   // request through the controller, held until ack
   task automatic issue(input cmd_e c, input logic [ADDR_W-1:0] a, input logic [4:0] exp);
      int n;
      if (exp != 5'h00) q1.push_back(exp);
      req_cmd_i = c;
      req_addr_i = a;
      req_i = 1'b1;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      if (ack_o !== 1'b1) chk(10'h001, 10'h000);
      req_i = 1'b0;
      @(negedge clk_i);
   endtask : issue
   // one command straight onto the fault-side pins
   task automatic pin(input cmd_e c, input logic [ADDR_W-1:0] a, input logic [4:0] exp);
      if (exp != 5'h00) q2.push_back(exp);
      {drv_if.cs_n, drv_if.ras_n, drv_if.cas_n, drv_if.we_n} = c;
      drv_if.addr = a;
      @(negedge clk_i);
   endtask : pin
   // quiet cycles: no operation or deselect with junk strobes, address toggling
   task automatic idle(input int n);
      logic [7:0] r;
      repeat (n)
      begin
         rnd(r);
         {drv_if.cs_n, drv_if.ras_n, drv_if.cas_n, drv_if.we_n} = r[7] ? {1'b1, r[2:0]} : 4'h7;
         drv_if.addr = ~drv_if.addr;
         @(negedge clk_i);
      end
   endtask : idle
   task automatic test_done();
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // clock, monitor, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // every pulse of a device end takes the oldest note of its queue
   always @(posedge clk_i)
   begin
      #1;
      if (!rst_i && (illegal_o !== 1'b0 || read_start_o !== 4'h0)) take(q1, {illegal_o, read_start_o});
      if (!rst_i && (illegal2 !== 1'b0 || rs2 !== 4'h0)) take(q2, {illegal2, rs2});
   end
   initial
   begin
      #100000;
      err_total++;
      test_done();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin : main_seq
      logic [7:0] r;
      logic b;
      rst_i = 1'b1;
      req_i = 1'b0;
      req_cmd_i = 4'h7;
      req_addr_i = 10'h000;
      {drv_if.cs_n, drv_if.ras_n, drv_if.cas_n, drv_if.we_n} = 4'h8;
      drv_if.addr = 10'h000;
      lfsr_reg = 32'hb0bdb19a;
      err_total = 0;
      comparisons = 0;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      rnd(r);
      issue(mode_set_cmd, {2'b01, r}, 5'h00);
      issue(refresh_cmd, 10'h000, 5'h00);
      for (int i = 0; i < 4; i++)
      begin
         rnd(r);
         b = r[0];
         issue(activate_cmd, {b, 9'h000}, 5'h00);
         issue(activate_cmd, {!b, 9'h000}, 5'h00);
         issue(read_cmd, {b, i[0], r}, {2'b00, i[0], 2'b01} << b);
         issue(write_cmd, {!b, 1'b0, r}, 5'h00);
         issue(precharge_cmd, {b, 9'h000}, 5'h00);
         issue(precharge_cmd, {!b, 9'h000}, 5'h00);
      end
      idle(2);
      pin(activate_cmd, 10'h000, 5'h00);
      pin(read_cmd, 10'h000, 5'h10);
      pin(activate_cmd, 10'h200, 5'h00);
      pin(write_cmd, 10'h200, 5'h10);
      idle(RCD_CYC + 2);
      chk(10'(active2), 10'h003);
      pin(read_cmd, {2'b00, r}, 5'h01);
      pin(write_cmd, 10'h000, 5'h00);
      idle(BURST_LEN);
      pin(activate_cmd, 10'h000, 5'h10);
      pin(write_cmd, 10'h000, 5'h00);
      idle(BURST_LEN);
      pin(read_cmd, 10'h000, 5'h01);
      idle(BURST_LEN + WR_CYC + 2);
      chk(10'(active2), 10'h003);
      pin(write_cmd, 10'h300, 5'h00);
      pin(read_cmd, 10'h200, 5'h10);
      idle(BURST_LEN + DAL_CYC + 3);
      chk(10'(idle2), 10'h002);
      pin(precharge_cmd, 10'h000, 5'h00);
      pin(precharge_cmd, 10'h000, 5'h00);
      pin(activate_cmd, 10'h000, 5'h10);
      idle(RP_CYC + 2);
      chk(10'(idle2), 10'h003);
      pin(refresh_cmd, 10'h000, 5'h00);
      pin(burst_stop_cmd, 10'h000, 5'h00);
      pin(activate_cmd, 10'h200, 5'h10);
      idle(RC_CYC + 2);
      chk(10'(idle2), 10'h003);
      rnd(r);
      pin(mode_set_cmd, {r[1:0], r}, 5'h00);
      chk(mode2, {r[1:0], r});
      pin(read_cmd, 10'h000, 5'h10);
      idle(MCD_CYC + 2);
      chk(10'(idle2), 10'h003);
      pin(activate_cmd, 10'h200, 5'h00);
      pin(refresh_cmd, 10'h000, 5'h10);
      idle(4);
      chk(10'(idle2), 10'h001);
      chk(10'(q1.size() + q2.size()), 10'h000);
      test_done();
   end
endmodule : tb
